// ===== core/tsh_pkg.sv
// Types shared by the touch sensitivity control files
package tsh_pkg;
	typedef enum logic [1:0] {
		TSH_HYST_OFF,
		TSH_HYST_SMALL,
		TSH_HYST_LARGE,
		TSH_HYST_RSVD
	} tsh_hyst_t;
	typedef enum logic {
		TSH_SCHEME_PRESET,
		TSH_SCHEME_CUSTOM
	} tsh_scheme_t;
endpackage

// ===== core/tsh_regs.svh
// Register offsets, field positions, reset values and timing counts for touch sensitivity control
`ifndef TSH_REGS_SVH
`define TSH_REGS_SVH
`define TSH_NUM_KEYS 8
`define TSH_LEVEL_W 3
`define TSH_THR_W 8
`define TSH_OFF_LEVEL 12'h000
`define TSH_OFF_CTRL 12'h004
`define TSH_OFF_STATUS 12'h008
`define TSH_OFF_SHARED_THR 12'h00C
`define TSH_OFF_KEY_THR 12'h010
`define TSH_OFF_KEY_THR_END 12'h02C
`define TSH_LEVEL_RESET 3'h4
`define TSH_LEVEL_MAX 3'h7
`define TSH_THR_RESET 8'h40
`define TSH_CTRL_SCHEME_BIT 0
`define TSH_CTRL_GUARD_BIT 1
`define TSH_CTRL_HYST_LO 2
`define TSH_CTRL_HYST_HI 3
`define TSH_ST_PRESSED_BIT 0
`define TSH_ST_HYST_BIT 1
`define TSH_ST_TRIM_BIT 2
`define TSH_ST_LEVEL_LO 4
`define TSH_ST_LEVEL_HI 6
`define TSH_TRIM_WAIT_CYC 8
`define TSH_TRIM_CNT_W 4
`endif

// ===== core/tsh_thr_mem.sv
// Small memory holding one threshold per touch key, registered read data
`include "tsh_regs.svh"
module tsh_thr_mem
	import tsh_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [2:0] wr_idx,
	input wire logic [`TSH_THR_W-1:0] wr_data,
	input wire logic [2:0] rd_idx,
	output logic [`TSH_THR_W-1:0] rd_data_q
);
	logic [`TSH_THR_W-1:0] mem_q [0:`TSH_NUM_KEYS-1];

	// Per-key storage; reset to 0x40, a quarter of full scale, so custom mode starts sane
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `TSH_NUM_KEYS; i++) begin
				mem_q[i] <= `TSH_THR_RESET;
			end
		end else if (wr_en) begin
			mem_q[wr_idx] <= wr_data;
		end
	end

	// Registered read port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_q <= `TSH_THR_RESET;
		end else begin
			rd_data_q <= mem_q[rd_idx];
		end
	end
endmodule

// ===== core/tsh_touch_trigger_level_ctrl.sv
// Touch sensitivity level, threshold scheme and hysteresis control with APB registers
//
// What this block does
// (RQ1) Three-bit level, 000 most, 111 least
// (RQ2) Build option picks preset or custom scheme
// (RQ3) Preset applies one threshold to all keys
// (RQ4) Custom holds one threshold per key
// (RQ5) Coupling guard only when option enabled
// (RQ6) Hysteresis option: small, large or off
// (RQ7) Small: level drops one while pressed
// (RQ8) Large: threshold halved while pressed
// (RQ9) Adjustment holds until all keys released
// (RQ10) Software waits eight cycles before trim read
// (RQ11) Trim resistor code loads readable level
// (RQ12) Small hysteresis saturates at level seven
// (RQ13) Halving is a truncating right shift
`include "tsh_regs.svh"
module tsh_touch_trigger_level_ctrl
	import tsh_pkg::*;
#(
	parameter tsh_scheme_t SCHEME = TSH_SCHEME_PRESET,
	parameter logic GUARD_EN = 1'b0,
	parameter tsh_hyst_t HYST = TSH_HYST_SMALL
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] external_trim_resistor_pad,
	input wire logic [`TSH_NUM_KEYS-1:0] key_pressed,
	input wire logic [2:0] key_sel,
	output logic [`TSH_LEVEL_W-1:0] eff_level_q,
	output logic [`TSH_THR_W-1:0] eff_threshold_q,
	output logic neighbor_coupling_guard_q,
	output logic hyst_active_q
);
	logic [`TSH_LEVEL_W+`TSH_NUM_KEYS-1:0] sync_q;
	logic [2:0] trim_code;
	logic [`TSH_NUM_KEYS-1:0] pressed;
	logic [`TSH_LEVEL_W-1:0] level_q;
	logic [`TSH_THR_W-1:0] shared_thr_q;
	logic [`TSH_THR_W-1:0] key_thr;
	logic [`TSH_TRIM_CNT_W-1:0] trim_cnt_q;
	logic trim_done_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic wr_fire;
	logic rd_fire;
	logic key_wr;
	logic [2:0] key_wr_idx;
	logic any_pressed;
	logic [`TSH_THR_W-1:0] base_thr;

	// Decode of an access to the per-key threshold window
	function automatic logic is_key_addr(input logic [11:0] a);
		return (a >= `TSH_OFF_KEY_THR) && (a <= `TSH_OFF_KEY_THR_END) && (a[1:0] == 2'h0);
	endfunction

	// Small hysteresis step, saturating at the least sensitive level
	function automatic logic [`TSH_LEVEL_W-1:0] level_down(input logic [`TSH_LEVEL_W-1:0] l);
		return (l == `TSH_LEVEL_MAX) ? `TSH_LEVEL_MAX : l + 3'h1; // RQ12
	endfunction

	// Pad levels are asynchronous, so they pass the synchroniser first
	tsh_trim_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({external_trim_resistor_pad, key_pressed}),
		.sync_q(sync_q)
	);

	assign trim_code = sync_q[`TSH_LEVEL_W+`TSH_NUM_KEYS-1:`TSH_NUM_KEYS];
	assign pressed = sync_q[`TSH_NUM_KEYS-1:0];
	assign any_pressed = |pressed;

	// APB access phase with zero wait states
	assign wr_fire = psel && penable && pwrite && pready_q;
	assign rd_fire = psel && penable && !pwrite && pready_q;
	assign key_wr = wr_fire && is_key_addr(paddr) && (SCHEME == TSH_SCHEME_CUSTOM); // RQ4
	assign key_wr_idx = 3'((paddr - `TSH_OFF_KEY_THR) >> 2);

	// Per-key thresholds live in a small memory; read index is the key being judged
	tsh_thr_mem u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(key_wr),
		.wr_idx(key_wr_idx),
		.wr_data(pwdata[`TSH_THR_W-1:0]),
		.rd_idx(key_sel),
		.rd_data_q(key_thr)
	);

	// Trim code settles after power-up; the count gates its one-time load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim_cnt_q <= '0;
			trim_done_q <= 1'b0;
		end else if (!trim_done_q) begin
			if (trim_cnt_q == `TSH_TRIM_CNT_W'(`TSH_TRIM_WAIT_CYC - 1)) begin
				trim_done_q <= 1'b1;
			end else begin
				trim_cnt_q <= trim_cnt_q + 4'h1;
			end
		end
	end

	// Level register: trim load once, then software may override
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= `TSH_LEVEL_RESET;
		end else if (wr_fire && paddr == `TSH_OFF_LEVEL) begin
			level_q <= pwdata[`TSH_LEVEL_W-1:0]; // RQ1
		end else if (!trim_done_q && trim_cnt_q == `TSH_TRIM_CNT_W'(`TSH_TRIM_WAIT_CYC - 1)) begin
			level_q <= trim_code; // RQ11
		end
	end

	// Shared threshold used by the preset scheme
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_thr_q <= `TSH_THR_RESET;
		end else if (wr_fire && paddr == `TSH_OFF_SHARED_THR) begin
			shared_thr_q <= pwdata[`TSH_THR_W-1:0];
		end
	end

	// Scheme chooses shared or per-key threshold
	assign base_thr = (SCHEME == TSH_SCHEME_PRESET) ? shared_thr_q : key_thr; // RQ2 RQ3 RQ4

	// Hysteresis tracks any press and drops only once all keys are free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hyst_active_q <= 1'b0;
		end else begin
			hyst_active_q <= (HYST == TSH_HYST_SMALL || HYST == TSH_HYST_LARGE) && any_pressed; // RQ6 RQ9
		end
	end

	// Effective level and threshold, registered for clean outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eff_level_q <= `TSH_LEVEL_RESET;
			eff_threshold_q <= `TSH_THR_RESET;
		end else begin
			eff_level_q <= level_q;
			eff_threshold_q <= base_thr;
			if (HYST == TSH_HYST_SMALL && any_pressed) begin
				eff_level_q <= level_down(level_q); // RQ7
			end
			if (HYST == TSH_HYST_LARGE && any_pressed) begin
				eff_threshold_q <= base_thr >> 1; // RQ8 RQ13
			end
		end
	end

	// Coupling guard is a build option; costs a little sensitivity
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			neighbor_coupling_guard_q <= 1'b0;
		end else begin
			neighbor_coupling_guard_q <= GUARD_EN; // RQ5
		end
	end

	// APB slave: always ready, error on unmapped addresses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= psel && !penable;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
			if (psel && !penable) begin
				case (paddr)
					`TSH_OFF_LEVEL: prdata_q <= {29'h0, level_q};
					`TSH_OFF_CTRL: prdata_q <= {28'h0, HYST, GUARD_EN, SCHEME};
					`TSH_OFF_STATUS: prdata_q <= {25'h0, eff_level_q, 1'b0, trim_done_q,
						hyst_active_q, any_pressed};
					`TSH_OFF_SHARED_THR: prdata_q <= {24'h0, shared_thr_q};
					default: begin
						if (is_key_addr(paddr) && SCHEME == TSH_SCHEME_CUSTOM) begin
							prdata_q <= {24'h0, key_thr};
						end else if (!is_key_addr(paddr)) begin
							pslverr_q <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// Small hysteresis lowers the level by one, saturating
	small_hyst_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
		(HYST == TSH_HYST_SMALL && any_pressed) |=> eff_level_q == level_down($past(level_q)))
		else $error("small hysteresis level wrong");
	// Large hysteresis halves the threshold
	large_hyst_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
		(HYST == TSH_HYST_LARGE && any_pressed) |=> eff_threshold_q == ($past(base_thr) >> 1))
		else $error("large hysteresis threshold wrong");
	// Release restores the programmed level
	release_level_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
		!any_pressed |=> eff_level_q == $past(level_q) && eff_threshold_q == $past(base_thr))
		else $error("level not restored after release");
	// Saturation at the least sensitive level
	sat_level_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
		(HYST == TSH_HYST_SMALL && any_pressed && level_q == `TSH_LEVEL_MAX) |=> eff_level_q == `TSH_LEVEL_MAX)
		else $error("level wrapped");
	// Trim code loaded after the settle count
	trim_load_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
		($rose(trim_done_q) && !$past(wr_fire)) |-> level_q == $past(trim_code))
		else $error("trim code not loaded");
	// Hysteresis flag follows any press
	hyst_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
		any_pressed && HYST != TSH_HYST_OFF |=> hyst_active_q)
		else $error("hysteresis flag missing");
	// Preset scheme uses shared threshold
	preset_thr_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
		(SCHEME == TSH_SCHEME_PRESET && !any_pressed) |=> eff_threshold_q == $past(shared_thr_q))
		else $error("preset threshold not shared");
	// Level write takes effect next cycle
	level_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
		(wr_fire && paddr == `TSH_OFF_LEVEL) |=> level_q == $past(pwdata[2:0]))
		else $error("level write lost");
	// Guard output follows its option
	guard_out_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
		$past(presetn) |-> neighbor_coupling_guard_q == GUARD_EN)
		else $error("guard option mismatch");
endmodule

// ===== core/tsh_trim_sync.sv
// Two-flop synchroniser for the trim resistor comparator code and key pressed levels
`include "tsh_regs.svh"
module tsh_trim_sync
	import tsh_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [`TSH_LEVEL_W+`TSH_NUM_KEYS-1:0] async_in,
	output logic [`TSH_LEVEL_W+`TSH_NUM_KEYS-1:0] sync_q
);
	logic [`TSH_LEVEL_W+`TSH_NUM_KEYS-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
endmodule

// ===== verif/test_tsh_touch_trigger_level_ctrl.sv
// Self-checking bench for the touch sensitivity control block
`include "tsh_regs.svh"
module test_tsh_touch_trigger_level_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [2:0] TRIM = 3'h2;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, guard, hyst;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic [2:0] key_sel, trim, eff_level;
	logic [7:0] touch_cmd, key_pressed, eff_thr;
	logic guard2, hyst2;
	logic [2:0] eff_level2;
	logic [7:0] eff_thr2;
	logic [7:0] thr [8];
	logic [32:0] exp_q [$];
	int bad_count, tests_run;

	// Custom scheme, guard on, small hysteresis: the richest build
	tsh_touch_trigger_level_ctrl #(.SCHEME(tsh_pkg::TSH_SCHEME_CUSTOM), .GUARD_EN(1'b1), .HYST(tsh_pkg::TSH_HYST_SMALL))
		tsh_touch_trigger_level_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_trim_resistor_pad(trim), .key_pressed(key_pressed), .key_sel(key_sel),
		.eff_level_q(eff_level), .eff_threshold_q(eff_thr), .neighbor_coupling_guard_q(guard),
		.hyst_active_q(hyst));
	// Preset scheme, guard off, large hysteresis: shares the bus, answers are not read back
	tsh_touch_trigger_level_ctrl #(.SCHEME(tsh_pkg::TSH_SCHEME_PRESET), .GUARD_EN(1'b0), .HYST(tsh_pkg::TSH_HYST_LARGE))
		tsh_touch_trigger_level_ctrl_large_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
		.external_trim_resistor_pad(trim), .key_pressed(key_pressed), .key_sel(key_sel),
		.eff_level_q(eff_level2), .eff_threshold_q(eff_thr2), .neighbor_coupling_guard_q(guard2),
		.hyst_active_q(hyst2));
	tsh_pad_model #(.TRIM_CODE(TRIM)) tsh_pad_model_i (.pclk(pclk), .touch_cmd(touch_cmd),
		.key_pressed(key_pressed), .external_trim_resistor_pad(trim));

	// Free-running 250 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic note(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// One APB transfer; held until pready is sampled high, then released
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// A slave that never answers is caught by the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
		exp_q.push_back({err, d});
		apb(1'b0, a, 32'h0);
	endtask

	// Outputs need three edges to follow the pads; five gives margin
	task automatic settle_check(input logic [2:0] lvl, input logic [7:0] th, input logic hy,
		input logic [2:0] lvl2, input logic [7:0] th2);
		repeat (5) @(posedge pclk);
		note(eff_level === lvl && eff_thr === th && hyst === hy, "effective outputs");
		note(eff_level2 === lvl2 && eff_thr2 === th2 && hyst2 === hy, "large build outputs");
	endtask

	// Read answers are judged at the edge where the slave answers
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) note(1'b0, "unexpected read");
			else note({pslverr, prdata} === exp_q.pop_front(), "read data");
		end
	end

	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge pclk);
		bad_count++;
		tally_and_finish();
	end

	initial begin
		logic [2:0] lv;
		logic [2:0] ef;
		logic [7:0] pr;
		logic [7:0] sthr;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		key_sel = 3'h0;
		touch_cmd = 8'h00;
		rnd = 32'h6DCD;
		bad_count = 0;
		tests_run = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// Software waits past the eight-cycle trim load before reading
		repeat (10) @(posedge pclk);
		rd(`TSH_OFF_LEVEL, {29'h0, TRIM}, 1'b0);
		rd(`TSH_OFF_CTRL, 32'h7, 1'b0);
		rd(`TSH_OFF_SHARED_THR, 32'h40, 1'b0);
		rd(12'h0FC, 32'h0, 1'b1);
		note(guard === 1'b1, "guard output");
		note(guard2 === 1'b0, "guard off build");
		// Odd shared threshold so the halving must drop a bit
		rnd = lfsr(rnd);
		sthr = rnd[7:0] | 8'h01;
		apb(1'b1, `TSH_OFF_SHARED_THR, {24'h0, sthr});
		rd(`TSH_OFF_SHARED_THR, {24'h0, sthr}, 1'b0);
		$display("test reset and trim done");
		// Every level code written over the trim value and read back
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, `TSH_OFF_LEVEL, 32'(i));
			rd(`TSH_OFF_LEVEL, 32'(i), 1'b0);
		end
		$display("test levels done");
		for (int k = 0; k < 8; k++) begin
			rnd = lfsr(rnd);
			thr[k] = rnd[7:0];
			apb(1'b1, `TSH_OFF_KEY_THR + 12'(4 * k), {24'h0, thr[k]});
		end
		for (int k = 0; k < 8; k++) begin
			key_sel <= 3'(k);
			@(posedge pclk);
			rd(`TSH_OFF_KEY_THR + 12'(4 * k), {24'h0, thr[k]}, 1'b0);
			settle_check(3'h7, thr[k], 1'b0, 3'h7, sthr);
		end
		$display("test key thresholds done");
		// Top level must saturate; partial release keeps the shift
		for (int j = 0; j < 3; j++) begin
			lv = (j == 0) ? 3'h7 : 3'(j * 3);
			ef = (lv == 3'h7) ? lv : lv + 3'h1;
			apb(1'b1, `TSH_OFF_LEVEL, {29'h0, lv});
			rnd = lfsr(rnd);
			pr = rnd[7:0] | 8'h81;
			touch_cmd <= pr;
			settle_check(ef, thr[7], 1'b1, lv, {1'b0, sthr[7:1]});
			rd(`TSH_OFF_STATUS, {25'h0, ef, 4'h7}, 1'b0);
			touch_cmd <= 8'h80;
			settle_check(ef, thr[7], 1'b1, lv, {1'b0, sthr[7:1]});
			touch_cmd <= 8'h00;
			settle_check(lv, thr[7], 1'b0, lv, sthr);
		end
		$display("test hysteresis done");
		tally_and_finish();
	end
endmodule

// ===== verif/tsh_pad_model.sv
// Behavioural model of the electrode pads and the trim resistor pad
module tsh_pad_model #(
	parameter logic [2:0] TRIM_CODE = 3'h2
)
(
	input wire logic pclk,
	input wire logic [7:0] touch_cmd,
	output logic [7:0] key_pressed,
	output logic [2:0] external_trim_resistor_pad
);
	timeunit 1ns;
	timeprecision 1ps;
	// Fitted resistor fixes the code from power-on, so the sync chain sees it settled
	assign external_trim_resistor_pad = TRIM_CODE;
	// Contacts start open so the synchroniser never sees an unknown
	initial key_pressed = 8'h00;
	// Finger contact follows the bench command one edge later
	always @(posedge pclk) begin
		key_pressed <= touch_cmd;
	end
endmodule
